// ---- hw/rtcal_cal.sv ----
// Purpose: once-a-minute calibration amount
// Assumes: minute_tick is a one-cycle pulse
// Notes:   emits signed pulse count for the timer counter
module rtcal_cal (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              minute_tick,
  input  wire logic [7:0]        cal_value,
  output logic                   adj_valid,
  output logic signed [9:0]      adj_pulses
);
  typedef struct packed {
    logic              valid;
    logic signed [9:0] pulses;
  } rtcal_cal_t;
  rtcal_cal_t s_q;
  rtcal_cal_t s_d;
  // scale by four, sign kept: 80h gives -512
  always_comb begin
    s_d        = s_q;
    s_d.valid  = minute_tick; // RQ5
    if (minute_tick) begin
      s_d.pulses = {{2{cal_value[7]}}, cal_value} <<< rtcal_pkg::CAL_SHIFT; // RQ6 RQ20
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign adj_valid  = s_q.valid;
  assign adj_pulses = s_q.pulses;
  a_cal_scale: assert property (@(posedge sys_clk) disable iff (!nrst)
    minute_tick |=> adj_valid && adj_pulses == $signed({{2{$past(cal_value[7])}}, $past(cal_value)}) * 4) // RQ5
    else $error("calibration amount not four times value");
  a_cal_neg_max: assert property (@(posedge sys_clk) disable iff (!nrst)
    (minute_tick && cal_value == 8'h80) |=> adj_pulses == 10'sh200) // RQ20
    else $error("max negative code not minus 512");
  a_cal_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (minute_tick && cal_value == 8'h00) |=> adj_pulses == 10'sd0) // RQ6
    else $error("zero code applied an adjustment");
endmodule

// ---- hw/rtcal_match.sv ----
// Purpose: alarm digit comparison for the selected interval
// Assumes: time and alarm digits given as packed BCD words
// Notes:   purely combinational
module rtcal_match (
  input  wire logic [3:0]  interval_sel,
  input  wire logic [15:0] alm_mthdy,
  input  wire logic [15:0] alm_wdhr,
  input  wire logic [15:0] alm_minsec,
  input  wire logic [15:0] now_mthdy,
  input  wire logic [15:0] now_wdhr,
  input  wire logic [15:0] now_minsec,
  output logic             hit
);
  logic s1;
  logic s10;
  logic m1;
  logic m10;
  logic hr;
  logic wd;
  logic dy;
  logic mo;
  // per-digit equality
  assign s1  = alm_minsec[3:0] == now_minsec[3:0];
  assign s10 = alm_minsec[6:4] == now_minsec[6:4];
  assign m1  = alm_minsec[11:8] == now_minsec[11:8];
  assign m10 = alm_minsec[14:12] == now_minsec[14:12];
  assign hr  = alm_wdhr[5:0] == now_wdhr[5:0];
  assign wd  = alm_wdhr[10:8] == now_wdhr[10:8];
  assign dy  = alm_mthdy[5:0] == now_mthdy[5:0];
  assign mo  = alm_mthdy[12:8] == now_mthdy[12:8];
  // select digits by interval; feb 29 only matches when it occurs
  always_comb begin
    unique case (interval_sel)
      rtcal_pkg::IV_HALF: hit = 1'b1; // RQ9
      rtcal_pkg::IV_SEC:  hit = 1'b1;
      rtcal_pkg::IV_10S:  hit = s1;
      rtcal_pkg::IV_MIN:  hit = s1 & s10;
      rtcal_pkg::IV_10M:  hit = s1 & s10 & m1;
      rtcal_pkg::IV_HOUR: hit = s1 & s10 & m1 & m10;
      rtcal_pkg::IV_DAY:  hit = s1 & s10 & m1 & m10 & hr;
      rtcal_pkg::IV_WEEK: hit = s1 & s10 & m1 & m10 & hr & wd;
      rtcal_pkg::IV_MON:  hit = s1 & s10 & m1 & m10 & hr & dy;
      rtcal_pkg::IV_YEAR: hit = s1 & s10 & m1 & m10 & hr & dy & mo; // RQ10
      default:            hit = 1'b0;
    endcase
  end
endmodule

// ---- hw/rtcal_pkg.sv ----
// Purpose: shared constants for the clock alarm and calibration block
// Assumes: APB word registers, 16-bit data in the low bits
// Notes:   digit fields are BCD
package rtcal_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CFG_CAL   = 8'h00;
  localparam logic [7:0] OFS_ALM_CFG   = 8'h04;
  localparam logic [7:0] OFS_ALM_HIGH  = 8'h08;
  localparam logic [7:0] OFS_ALM_LOW   = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  // alarm config / repeat fields
  localparam int ALM_EN_BIT    = 15;
  localparam int CHIME_BIT     = 14;
  localparam int MASK_LSB      = 10;
  localparam int PTR_LSB       = 8;
  // configuration / calibration fields
  localparam int CLK_ON_BIT    = 15;
  localparam int UNLOCK_BIT    = 13;
  // field masks of the three value registers
  localparam logic [15:0] MTHDY_MASK   = 16'h1F3F;
  localparam logic [15:0] WDHR_MASK    = 16'h073F;
  localparam logic [15:0] MINSEC_MASK  = 16'h7F7F;
  localparam logic [1:0]  PTR_MTHDY    = 2'h2;
  localparam logic [1:0]  PTR_WDHR     = 2'h1;
  localparam logic [1:0]  PTR_MINSEC   = 2'h0;
  localparam logic [7:0]  RPT_MAX      = 8'hFF;
  // pulses per calibration step
  localparam int CAL_STEP_PULSES = 4;
  localparam int CAL_SHIFT       = 2;
  // interval codes
  localparam logic [3:0] IV_HALF = 4'h0;
  localparam logic [3:0] IV_SEC  = 4'h1;
  localparam logic [3:0] IV_10S  = 4'h2;
  localparam logic [3:0] IV_MIN  = 4'h3;
  localparam logic [3:0] IV_10M  = 4'h4;
  localparam logic [3:0] IV_HOUR = 4'h5;
  localparam logic [3:0] IV_DAY  = 4'h6;
  localparam logic [3:0] IV_WEEK = 4'h7;
  localparam logic [3:0] IV_MON  = 4'h8;
  localparam logic [3:0] IV_YEAR = 4'h9;
endpackage

// ---- hw/rtcal_top.sv ----
// Purpose: alarm and calibration part of a real-time clock unit
// Assumes: time digits and ticks arrive synchronous to sys_clk
// Notes:   APB slave, 16-bit registers in low half of each word
// What this block does
// RQ1 - month/day alarm digits, unused bits zero
// RQ2 - weekday/hour alarm digits, unused bits zero
// RQ3 - minute/second alarm digits, bits 15,7 zero
// RQ4 - month/day, weekday/hour writes need unlock
// RQ5 - signed calibration times four each minute
// RQ6 - each step is four clock pulses
// RQ7 - software writes calibration at safe times
// RQ8 - software writes alarm values while disabled
// RQ9 - interval field selects matched digits
// RQ10 - yearly feb 29 fires only when occurring
// RQ11 - zero repeat, no chime: one alarm
// RQ12 - decrement per alarm, final clears enable
// RQ13 - FFh gives 255 repeats
// RQ14 - chime wraps counter, enable stays
// RQ15 - interrupt request on every alarm
// RQ16 - alarm pulse toggles each event
// RQ17 - software changes values only when disabled
// RQ18 - software changes config when sync low
// RQ19 - window pointer decrements on high access
// RQ20 - 80h subtracts 512 pulses, zero nothing
// RQ21 - software avoids reserved interval codes
// RQ22 - match checked each half-second when enabled
// RQ23 - value registers load before enable
//
// The register addresses and the APB slave port were decided locally.
module rtcal_top (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        half_sec_tick,
  input  wire logic        minute_tick,
  input  wire logic        clock_rollover_sync_flag,
  input  wire logic [15:0] now_mthdy,
  input  wire logic [15:0] now_wdhr,
  input  wire logic [15:0] now_minsec,
  output logic             alarm_irq,
  output logic             alarm_pulse,
  output logic             cal_adj_valid,
  output logic signed [9:0] cal_adj_pulses
);
  typedef struct packed {
    logic [15:0] cfg_cal;
    logic        alarm_enable;
    logic        chime;
    logic [3:0]  alarm_interval_select;
    logic [1:0]  alarm_window_pointer;
    logic [7:0]  alarm_repeat_count;
    logic [15:0] alm_mthdy;
    logic [15:0] alm_wdhr;
    logic [15:0] alm_minsec;
    logic        irq;
    logic        pulse;
    logic [31:0] rdata;
  } rtcal_state_t;
  rtcal_state_t s_q;
  rtcal_state_t s_d;
  logic hit;
  logic wr;
  logic rd;
  logic mapped;
  logic event_now;
  logic [15:0] win_val;
  logic [15:0] cfg_word;
  logic clock_write_unlock;

  // unmasked value read through the pointer, high and low halves
  function automatic logic [15:0] win_read(input logic [1:0] ptr, input logic [15:0] md,
                                           input logic [15:0] wh, input logic [15:0] ms);
    unique case (ptr)
      rtcal_pkg::PTR_MTHDY:  win_read = md;
      rtcal_pkg::PTR_WDHR:   win_read = wh;
      rtcal_pkg::PTR_MINSEC: win_read = ms;
      default:               win_read = 16'h0000;
    endcase
  endfunction

  rtcal_match u_match (
    .interval_sel (s_q.alarm_interval_select),
    .alm_mthdy    (s_q.alm_mthdy),
    .alm_wdhr     (s_q.alm_wdhr),
    .alm_minsec   (s_q.alm_minsec),
    .now_mthdy    (now_mthdy),
    .now_wdhr     (now_wdhr),
    .now_minsec   (now_minsec),
    .hit          (hit)
  );

  rtcal_cal u_cal (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .minute_tick (minute_tick && s_q.cfg_cal[rtcal_pkg::CLK_ON_BIT]),
    .cal_value   (s_q.cfg_cal[7:0]),
    .adj_valid   (cal_adj_valid),
    .adj_pulses  (cal_adj_pulses)
  );

  // bus decode, zero-wait answer
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign mapped = paddr == rtcal_pkg::OFS_CFG_CAL || paddr == rtcal_pkg::OFS_ALM_CFG ||
                  paddr == rtcal_pkg::OFS_ALM_HIGH || paddr == rtcal_pkg::OFS_ALM_LOW ||
                  paddr == rtcal_pkg::OFS_STATUS;
  assign clock_write_unlock = s_q.cfg_cal[rtcal_pkg::UNLOCK_BIT];
  assign event_now = s_q.alarm_enable && half_sec_tick && hit; // RQ22
  assign win_val   = win_read(s_q.alarm_window_pointer, s_q.alm_mthdy, s_q.alm_wdhr, s_q.alm_minsec);
  assign cfg_word  = {s_q.alarm_enable, s_q.chime, s_q.alarm_interval_select,
                      s_q.alarm_window_pointer, s_q.alarm_repeat_count};

  // next state: bus writes then alarm events, hardware wins
  always_comb begin
    s_d     = s_q;
    s_d.irq = 1'b0;
    if (wr) begin
      unique case (paddr)
        rtcal_pkg::OFS_CFG_CAL: s_d.cfg_cal = pwdata[15:0];
        rtcal_pkg::OFS_ALM_CFG: begin
          s_d.alarm_enable          = pwdata[rtcal_pkg::ALM_EN_BIT];
          s_d.chime                 = pwdata[rtcal_pkg::CHIME_BIT];
          s_d.alarm_interval_select = pwdata[13:10];
          s_d.alarm_window_pointer  = pwdata[9:8];
          s_d.alarm_repeat_count    = pwdata[7:0];
        end
        rtcal_pkg::OFS_ALM_HIGH: begin
          unique case (s_q.alarm_window_pointer)
            rtcal_pkg::PTR_MTHDY: if (clock_write_unlock) begin // RQ4
              s_d.alm_mthdy[15:8] = pwdata[15:8] & rtcal_pkg::MTHDY_MASK[15:8]; // RQ1
            end
            rtcal_pkg::PTR_WDHR: if (clock_write_unlock) begin // RQ4
              s_d.alm_wdhr[15:8] = pwdata[15:8] & rtcal_pkg::WDHR_MASK[15:8]; // RQ2
            end
            rtcal_pkg::PTR_MINSEC: s_d.alm_minsec[15:8] = pwdata[15:8] & rtcal_pkg::MINSEC_MASK[15:8]; // RQ3
            default: s_d.alm_minsec = s_q.alm_minsec;
          endcase
        end
        rtcal_pkg::OFS_ALM_LOW: begin
          unique case (s_q.alarm_window_pointer)
            rtcal_pkg::PTR_MTHDY: if (clock_write_unlock) begin // RQ4
              s_d.alm_mthdy[7:0] = pwdata[7:0] & rtcal_pkg::MTHDY_MASK[7:0]; // RQ1
            end
            rtcal_pkg::PTR_WDHR: if (clock_write_unlock) begin // RQ4
              s_d.alm_wdhr[7:0] = pwdata[7:0] & rtcal_pkg::WDHR_MASK[7:0]; // RQ2
            end
            rtcal_pkg::PTR_MINSEC: s_d.alm_minsec[7:0] = pwdata[7:0] & rtcal_pkg::MINSEC_MASK[7:0]; // RQ3
            default: s_d.alm_minsec = s_q.alm_minsec;
          endcase
        end
        default: s_d.cfg_cal = s_q.cfg_cal;
      endcase
    end
    // pointer steps down on any high-half access, sticks at zero
    if ((wr || rd) && paddr == rtcal_pkg::OFS_ALM_HIGH && s_q.alarm_window_pointer != 2'h0) begin
      s_d.alarm_window_pointer = s_q.alarm_window_pointer - 2'h1; // RQ19
    end
    // alarm event: irq, toggle, repeat count
    if (event_now) begin
      s_d.irq   = 1'b1; // RQ15
      s_d.pulse = !s_q.pulse; // RQ16
      if (s_q.alarm_repeat_count != 8'h00) begin
        s_d.alarm_repeat_count = s_q.alarm_repeat_count - 8'h01; // RQ12 RQ13
      end else if (s_q.chime) begin
        s_d.alarm_repeat_count = rtcal_pkg::RPT_MAX; // RQ14
      end else begin
        s_d.alarm_enable = 1'b0; // RQ11 RQ12
      end
    end
    // read data
    s_d.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        rtcal_pkg::OFS_CFG_CAL:  s_d.rdata = {16'h0000, s_q.cfg_cal};
        rtcal_pkg::OFS_ALM_CFG:  s_d.rdata = {16'h0000, cfg_word};
        rtcal_pkg::OFS_ALM_HIGH: s_d.rdata = {16'h0000, win_val[15:8], 8'h00};
        rtcal_pkg::OFS_ALM_LOW:  s_d.rdata = {24'h000000, win_val[7:0]};
        rtcal_pkg::OFS_STATUS:   s_d.rdata = {30'h0, s_q.pulse, clock_rollover_sync_flag};
        default:                 s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // value registers power up unknown; all other state resets
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q.cfg_cal               <= 16'h0000;
      s_q.alarm_enable          <= 1'b0;
      s_q.chime                 <= 1'b0;
      s_q.alarm_interval_select <= 4'h0;
      s_q.alarm_window_pointer  <= 2'h0;
      s_q.alarm_repeat_count    <= 8'h00;
      s_q.irq                   <= 1'b0;
      s_q.pulse                 <= 1'b0;
      s_q.rdata                 <= 32'h0000_0000;
    end else begin
      s_q <= s_d; // RQ23
    end
  end

  // read data is combinational in access phase, registered copy held for one cycle after it
  assign prdata      = rd ? s_d.rdata : s_q.rdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped;
  assign alarm_irq   = s_q.irq;
  assign alarm_pulse = s_q.pulse;

  a_irq_per_event: assert property (@(posedge sys_clk) disable iff (!nrst)
    event_now |=> alarm_irq) // RQ15
    else $error("alarm event without interrupt");
  a_pulse_toggle: assert property (@(posedge sys_clk) disable iff (!nrst)
    event_now |=> alarm_pulse != $past(alarm_pulse)) // RQ16
    else $error("alarm pulse did not toggle");
  a_pulse_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !event_now |=> $stable(alarm_pulse)) // RQ16
    else $error("alarm pulse moved without event");
  a_last_disables: assert property (@(posedge sys_clk) disable iff (!nrst)
    (event_now && s_q.alarm_repeat_count == 8'h00 && !s_q.chime && !wr) |=> !s_q.alarm_enable) // RQ11
    else $error("final alarm left enable set");
  a_chime_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    (event_now && s_q.alarm_repeat_count == 8'h00 && s_q.chime && !wr)
      |=> s_q.alarm_enable && s_q.alarm_repeat_count == 8'hFF) // RQ14
    else $error("chime did not wrap repeat count");
  a_repeat_dec: assert property (@(posedge sys_clk) disable iff (!nrst)
    (event_now && s_q.alarm_repeat_count != 8'h00 && !wr)
      |=> s_q.alarm_repeat_count == $past(s_q.alarm_repeat_count) - 8'h01 && s_q.alarm_enable) // RQ12
    else $error("repeat count not decremented");
  a_lock_mthdy: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr && !clock_write_unlock && s_q.alarm_window_pointer == 2'h2) |=> $stable(s_q.alm_mthdy)) // RQ4
    else $error("locked month day write took effect");
  a_ptr_step: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((wr || rd) && paddr == 8'h08 && s_q.alarm_window_pointer == 2'h2)
      |=> s_q.alarm_window_pointer == 2'h1) // RQ19
    else $error("window pointer did not step down");
  a_no_event_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!s_q.alarm_enable) |=> !alarm_irq) // RQ22
    else $error("interrupt while alarm disabled");
  a_lock_wdhr: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr && !clock_write_unlock && s_q.alarm_window_pointer == rtcal_pkg::PTR_WDHR)
      |=> $stable(s_q.alm_wdhr)) // RQ4
    else $error("locked weekday hour write took effect");
  a_ptr_floor: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((wr || rd) && paddr == rtcal_pkg::OFS_ALM_HIGH && s_q.alarm_window_pointer == 2'h0)
      |=> s_q.alarm_window_pointer == 2'h0) // RQ19
    else $error("window pointer went below zero");
  a_cal_gated: assert property (@(posedge sys_clk) disable iff (!nrst)
    (minute_tick && !s_q.cfg_cal[rtcal_pkg::CLK_ON_BIT]) |=> !cal_adj_valid) // RQ5
    else $error("calibration applied while clock off");
endmodule

// ---- test/rtcal_top_test.sv ----
// Purpose: self-checking bench for the alarm and calibration block
// Assumes: zero-wait APB slave, window bytes in place in the data word
// Notes:   seed fixed, expectations built from package masks
module rtcal_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, r;
  logic              half_sec_tick, minute_tick, sync_flag;
  logic [15:0]       now_mthdy, now_wdhr, now_minsec;
  logic              alarm_irq, alarm_pulse, cal_adj_valid, pulse_exp, fire, e;
  logic signed [9:0] cal_adj_pulses;
  logic [15:0]       ev [3];
  logic [47:0]       m, nw, alm;
  logic [7:0]        rpt, c;
  logic [7:0]        cals [5] = '{8'h00, 8'h01, 8'hFF, 8'h80, 8'h7F};
  int                fails, checked;

  rtcal_top u_rtcal_top (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .half_sec_tick(half_sec_tick), .minute_tick(minute_tick), .clock_rollover_sync_flag(sync_flag),
    .now_mthdy(now_mthdy), .now_wdhr(now_wdhr), .now_minsec(now_minsec), .alarm_irq(alarm_irq),
    .alarm_pulse(alarm_pulse), .cal_adj_valid(cal_adj_valid), .cal_adj_pulses(cal_adj_pulses));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // verdict and end of run
  task automatic stop_test;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic calcfg(input logic on, input logic unl, input logic [7:0] cal);
    apb(1'b1, rtcal_pkg::OFS_CFG_CAL, {16'h0000, on, 1'b0, unl, 5'h00, cal});
  endtask

  task automatic almcfg(input logic en, input logic ch, input logic [3:0] iv, input logic [1:0] p,
                        input logic [7:0] n);
    sync_flag <= 1'b0;
    apb(1'b1, rtcal_pkg::OFS_ALM_CFG, {16'h0000, en, ch, iv, p, n});
  endtask

  // load all three value registers through the window, alarm disabled
  task automatic put_values(input logic [15:0] v2, input logic [15:0] v1, input logic [15:0] v0);
    logic [15:0] v [3];
    v[2] = v2; v[1] = v1; v[0] = v0;
    almcfg(1'b0, 1'b0, 4'h0, rtcal_pkg::PTR_MTHDY, 8'h00);
    for (int p = 2; p >= 0; p--) begin
      apb(1'b1, rtcal_pkg::OFS_ALM_LOW, {16'h0000, v[p]});
      apb(1'b1, rtcal_pkg::OFS_ALM_HIGH, {16'h0000, v[p]});
    end
  endtask

  // read back through the window, pointer walks down and stops at zero
  task automatic check_values;
    almcfg(1'b0, 1'b0, 4'h0, rtcal_pkg::PTR_MTHDY, 8'h00);
    for (int p = 2; p >= 0; p--) begin
      apb(1'b0, rtcal_pkg::OFS_ALM_LOW, 32'h0);
      check(r, {24'h0, ev[p][7:0]}, "value low");
      apb(1'b0, rtcal_pkg::OFS_ALM_HIGH, 32'h0);
      check(r, {16'h0, ev[p][15:8], 8'h00}, "value high");
    end
    apb(1'b0, rtcal_pkg::OFS_ALM_CFG, 32'h0);
    check({30'h0, r[9:8]}, 32'h0, "pointer floor");
    almcfg(1'b0, 1'b0, 4'h0, 2'h3, 8'h00);
    apb(1'b0, rtcal_pkg::OFS_ALM_HIGH, 32'h0);
    check(r, 32'h0, "empty slot");
  endtask

  // one half-second tick with the given time, irq and pulse one cycle later
  task automatic tick(input logic [47:0] t, input logic f);
    @(posedge sys_clk);
    half_sec_tick <= 1'b1;
    {now_mthdy, now_wdhr, now_minsec} <= t;
    sync_flag <= 1'($urandom);
    @(posedge sys_clk);
    half_sec_tick <= 1'b0;
    #1;
    check({31'h0, alarm_irq}, {31'h0, f}, "irq");
    if (f) pulse_exp = ~pulse_exp;
    check({31'h0, alarm_pulse}, {31'h0, pulse_exp}, "pulse");
  endtask

  task automatic minute(input logic f);
    @(posedge sys_clk);
    minute_tick <= 1'b1;
    @(posedge sys_clk);
    minute_tick <= 1'b0;
    #1;
    check({31'h0, cal_adj_valid}, {31'h0, f}, "cal valid");
    if (f) check({22'h0, cal_adj_pulses}, {22'h0, c, 2'b00}, "cal pulses");
  endtask

  // digits compared for each interval code
  function automatic logic [47:0] iv_mask(input logic [3:0] iv);
    case (iv)
      rtcal_pkg::IV_10S:  iv_mask = 48'h0000_0000_000F;
      rtcal_pkg::IV_MIN:  iv_mask = 48'h0000_0000_007F;
      rtcal_pkg::IV_10M:  iv_mask = 48'h0000_0000_0F7F;
      rtcal_pkg::IV_HOUR: iv_mask = 48'h0000_0000_7F7F;
      rtcal_pkg::IV_DAY:  iv_mask = 48'h0000_003F_7F7F;
      rtcal_pkg::IV_WEEK: iv_mask = 48'h0000_073F_7F7F;
      rtcal_pkg::IV_MON:  iv_mask = 48'h003F_003F_7F7F;
      rtcal_pkg::IV_YEAR: iv_mask = 48'h1F3F_003F_7F7F;
      default:            iv_mask = 48'h0;
    endcase
  endfunction

  // run limit
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    stop_test();
  end

  // main sequence
  initial begin
    {nrst, psel, penable, pwrite, half_sec_tick, minute_tick, sync_flag, pulse_exp} = '0;
    paddr = 8'h00; pwdata = 32'h0; {now_mthdy, now_wdhr, now_minsec} = 48'h0;
    fails = 0; checked = 0;
    void'($urandom(81104));
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, rtcal_pkg::OFS_ALM_CFG, 32'h0);
    check(r, 32'h0, "alarm cfg reset");
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    apb(1'b0, 8'h14, 32'h0);
    check({e, r[30:0]}, 32'h8000_0000, "unmapped");
    // unlocked writes land, unused bits read zero
    calcfg(1'b0, 1'b1, 8'h00);
    for (int p = 0; p < 3; p++) ev[p] = 16'($urandom);
    put_values(ev[2], ev[1], ev[0]);
    ev[2] &= rtcal_pkg::MTHDY_MASK; ev[1] &= rtcal_pkg::WDHR_MASK; ev[0] &= rtcal_pkg::MINSEC_MASK;
    check_values();
    // locked: only minute/second changes
    calcfg(1'b0, 1'b0, 8'h00);
    c = 8'($urandom);
    put_values(~ev[2], ~ev[1], {c, c});
    ev[0] = {c, c} & rtcal_pkg::MINSEC_MASK;
    check_values();
    calcfg(1'b0, 1'b1, 8'h00);
    // repeat count 2, no chime: three alarms then off
    almcfg(1'b1, 1'b0, rtcal_pkg::IV_HALF, 2'h0, 8'h02);
    for (int k = 0; k < 4; k++) begin
      tick(48'($urandom), k < 3);
      apb(1'b0, rtcal_pkg::OFS_ALM_CFG, 32'h0);
      check(r, {16'h0, 1'(k < 2), 7'h00, 8'((k < 2) ? 1 - k : 0)}, "repeat");
    end
    almcfg(1'b1, 1'b0, rtcal_pkg::IV_SEC, 2'h0, rtcal_pkg::RPT_MAX);
    tick(48'h0, 1'b1);
    apb(1'b0, rtcal_pkg::OFS_ALM_CFG, 32'h0);
    check(r, {16'h0, 8'h84, 8'hFE}, "max repeat");
    almcfg(1'b1, 1'b1, rtcal_pkg::IV_SEC, 2'h0, 8'h00);
    tick(48'h0, 1'b1);
    apb(1'b0, rtcal_pkg::OFS_ALM_CFG, 32'h0);
    check(r, {16'h0, 8'hC4, 8'hFF}, "chime wrap");
    // every interval code, matching and off by one digit bit
    alm = {ev[2], ev[1], ev[0]};
    for (int iv = 0; iv < 10; iv++) begin
      for (int t = 0; t < 6; t++) begin
        rpt = 8'($urandom);
        almcfg(1'b1, 1'b1, 4'(iv), 2'h0, rpt);
        m = iv_mask(4'(iv));
        nw = (alm & m) | ({16'($urandom), 16'($urandom), 16'($urandom)} & ~m);
        if (t[0]) nw ^= m & -m;
        fire = ((nw ^ alm) & m) == 48'h0;
        tick(nw, fire);
        apb(1'b0, rtcal_pkg::OFS_ALM_CFG, 32'h0);
        check({24'h0, r[7:0]}, {24'h0, fire ? rpt - 8'h01 : rpt}, "count");
        apb(1'b0, rtcal_pkg::OFS_STATUS, 32'h0);
        check(r, {30'h0, pulse_exp, sync_flag}, "status");
      end
    end
    // yearly alarm on the leap day
    put_values(16'h0229, ev[1], ev[0]);
    almcfg(1'b1, 1'b1, rtcal_pkg::IV_YEAR, 2'h0, 8'h05);
    tick({16'h0228, ev[1], ev[0]}, 1'b0);
    tick({16'h0229, ev[1], ev[0]}, 1'b1);
    // calibration: off ignores the tick, on gives value times four
    for (int k = 0; k < 9; k++) begin
      c = (k < 5) ? cals[k] : 8'($urandom);
      calcfg(1'b1, 1'b1, c);
      minute(1'b1);
      calcfg(1'b0, 1'b1, c);
      minute(1'b0);
    end
    // reset in mid run clears the alarm configuration
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    pulse_exp = 1'b0;
    apb(1'b0, rtcal_pkg::OFS_ALM_CFG, 32'h0);
    check(r, 32'h0, "cfg after reset");
    check({19'h0, cal_adj_pulses, cal_adj_valid, alarm_pulse, alarm_irq}, 32'h0, "outputs after reset");
    stop_test();
  end
endmodule
